//--- rtl/i2c_mm_ctrl.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - serial data register shifts on the bus clock falling edge after each of the eight data bits, not after the acknowledge bit
// - transmit bits leave through an output latch, most significant bit first
// - data line is sampled into the serial path on the bus clock rising edge of each of the eight data bits
// - master sends slave address, then direction bit, before data bytes
// - reservation on: start held until bus release; slave when addressed
// - slave transmitter sends while master acknowledges, stops on missing acknowledge
// - slave receiver withholds acknowledge after last byte; master then stops
// - stop detection raises transfer interrupt only with stop irq enable set
module i2c_mm_ctrl
   import i2c_mm_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              bus_clock_pin_in,
   output logic                   bus_clock_pin_out,
   output logic                   bus_clock_pin_oe,
   input  wire logic              bus_data_pin_in,
   output logic                   bus_data_pin_out,
   output logic                   bus_data_pin_oe,
   output logic                   transfer_irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // storage

   logic [7:0]  ctl;
   logic [1:0]  flag_cfg;
   logic [7:0]  div_half;
   logic [7:0]  own_addr;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_mask;
   logic [7:0]  div_cnt;
   logic        scl_m;
   logic        scl_q;
   logic        scl_d;
   logic        sda_m;
   logic        sda_q;
   logic        sda_d;
   eng_state_e  state;
   logic [1:0]  ph;
   logic [7:0]  shift_data_reg;
   logic        out_latch;
   logic        rx_bit;
   logic [3:0]  bit_cnt;
   logic        skip_fall;
   logic        addr_phase;
   logic        master_state_bit;
   logic        slave_on;
   logic        direction_bit;
   logic        ack_detect_flag;
   logic        start_detect_flag;
   logic        stop_detect_flag;
   logic        addr_match_flag;
   logic        ext_code_flag;
   logic        bus_busy_flag;
   logic        start_reject_flag;
   logic        start_request;
   logic        stop_request;
   logic        en_d;
   logic        evt_xfer;
   logic        evt_arb;
   logic        evt_rej;
   line_drive_s drv;

   ////////////////////////////////////////////////////////////////////////////////
   // decoding

   wire controller_enable          = ctl[CTL_ENABLE];
   wire ack_enable                 = ctl[CTL_ACK_EN];
   wire wait_timing_select         = ctl[CTL_WAIT_SEL];
   wire stop_irq_enable            = ctl[CTL_STOP_IE];
   wire reservation_disable        = flag_cfg[FL_RSV_DIS];
   wire start_without_stop_enable  = flag_cfg[FL_NO_STOP];

   wire wr_shift   = reg_wr & (reg_addr == OFF_SHIFT);
   wire wr_ctl     = reg_wr & (reg_addr == OFF_CONTROL);
   wire wr_flag    = reg_wr & (reg_addr == OFF_FLAG);
   wire wr_clksel  = reg_wr & (reg_addr == OFF_CLKSEL);
   wire wr_ownadr  = reg_wr & (reg_addr == OFF_OWNADR);
   wire wr_irqstat = reg_wr & (reg_addr == OFF_IRQSTAT);
   wire wr_irqmask = reg_wr & (reg_addr == OFF_IRQMASK);

   wire tick       = (div_cnt == 8'h00);
   wire scl_rise   = scl_q & ~scl_d;
   wire scl_fall   = ~scl_q & scl_d;
   wire start_seen = scl_q & scl_d & ~sda_q & sda_d;
   wire stop_seen  = scl_q & scl_d & sda_q & ~sda_d;
   wire bit_fall   = scl_fall & ~skip_fall;
   wire in_byte    = (bit_cnt < BIT_ACK);

   wire [7:0] shift_next = {shift_data_reg[6:0], rx_bit};
   wire addr_hit   = (shift_next[7:1] == own_addr[7:1]);
   wire ext_hit    = (shift_next[7:4] == 4'h0);
   wire last_fall  = bit_fall & (bit_cnt == BIT_LAST);
   wire ack_fall   = bit_fall & (bit_cnt == BIT_ACK);
   wire wait_hit   = wait_timing_select ? ack_fall : last_fall;
   wire to_slave   = addr_phase & last_fall & ~master_state_bit & addr_hit;
   wire part_now   = master_state_bit | slave_on | to_slave;

   // transmitter of the current byte: address byte always from the master
   wire tx_now = addr_phase ? master_state_bit
               : (master_state_bit ? direction_bit : slave_on & direction_bit);
   wire rx_now = addr_phase ? slave_on
               : (master_state_bit ? ~direction_bit : slave_on & ~direction_bit);
   wire drive_low = in_byte ? (tx_now & ~out_latch)
                            : (rx_now & ack_enable);
   wire slave_nak = ack_fall & slave_on & ~addr_phase & direction_bit
                  & ~ack_detect_flag;
   wire arb_lost  = scl_rise & in_byte & master_state_bit & tx_now
                  & out_latch & ~sda_q & (state == S_XFER);
   wire wait_free = wr_shift | (wr_ctl & reg_wdata[CTL_WAIT_REL]);

   wire [7:0] status_word = {master_state_bit, 1'b0, ext_code_flag, addr_match_flag,
                             direction_bit, stop_detect_flag, start_detect_flag,
                             ack_detect_flag};
   wire [7:0] flag_word   = {start_reject_flag, bus_busy_flag, 4'h0, flag_cfg};
   wire [7:0] ctl_word    = {ctl[7:6], 1'b0, ctl[4:2], stop_request, start_request};

   logic [DATA_W-1:0] rd_word;
   always_comb begin
      unique case (reg_addr)
         OFF_SHIFT:   rd_word = {8'h00, shift_data_reg};
         OFF_CONTROL: rd_word = {8'h00, ctl_word};
         OFF_STATUS:  rd_word = {8'h00, status_word};
         OFF_FLAG:    rd_word = {8'h00, flag_word};
         OFF_CLKSEL:  rd_word = {div_half, 6'h00, scl_q, sda_q};
         OFF_OWNADR:  rd_word = {8'h00, own_addr};
         OFF_IRQSTAT: rd_word = {13'h0000, irq_stat};
         OFF_IRQMASK: rd_word = {13'h0000, irq_mask};
         default:     rd_word = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register port and interrupt

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctl      <= CTL_RST;
         flag_cfg <= FLAG_RST;
         div_half <= DIV_RST;
         own_addr <= OWNADR_RST;
         irq_mask <= IRQ_RST;
      end else begin
         if (wr_ctl) begin
            ctl <= {reg_wdata[7:6], 1'b0, reg_wdata[4:2], 2'b00};
         end
         if (wr_flag) begin
            flag_cfg <= reg_wdata[1:0];
         end
         if (wr_clksel) begin
            div_half <= reg_wdata[15:8];
         end
         if (wr_ownadr) begin
            own_addr <= {reg_wdata[7:1], 1'b0};
         end
         if (wr_irqmask) begin
            irq_mask <= reg_wdata[2:0];
         end
      end
   end

   // an event in the clearing cycle survives the clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_stat     <= IRQ_RST;
         transfer_irq <= 1'b0;
         reg_rdata    <= '0;
      end else begin
         irq_stat     <= (irq_stat & ~(wr_irqstat ? reg_wdata[2:0] : 3'h0))
                         | {evt_rej, evt_arb, evt_xfer};
         transfer_irq <= |(irq_stat & irq_mask);
         reg_rdata    <= reg_rd ? rd_word : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus clock divider

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         scl_m   <= 1'b1;
         scl_q   <= 1'b1;
         scl_d   <= 1'b1;
         sda_m   <= 1'b1;
         sda_q   <= 1'b1;
         sda_d   <= 1'b1;
         div_cnt <= DIV_RST;
      end else begin
         scl_m   <= bus_clock_pin_in;
         scl_q   <= scl_m;
         scl_d   <= scl_q;
         sda_m   <= bus_data_pin_in;
         sda_q   <= sda_m;
         sda_d   <= sda_q;
         div_cnt <= tick ? div_half : div_cnt - 8'h01;
      end
   end

   assign bus_clock_pin_out = 1'b0;
   assign bus_data_pin_out  = 1'b0;
   assign bus_clock_pin_oe  = drv.clk_low;
   assign bus_data_pin_oe   = drv.dat_low;

   ////////////////////////////////////////////////////////////////////////////////
   // bit and byte engine

   always_ff @(posedge ref_clk) begin
      evt_xfer <= 1'b0;
      evt_arb  <= 1'b0;
      evt_rej  <= 1'b0;
      en_d     <= controller_enable;
      if (srst | ~controller_enable) begin
         state             <= S_IDLE;
         ph                <= 2'h0;
         drv               <= '0;
         shift_data_reg    <= 8'h00;
         out_latch         <= 1'b1;
         rx_bit            <= 1'b1;
         bit_cnt           <= 4'h0;
         skip_fall         <= 1'b0;
         addr_phase        <= 1'b0;
         master_state_bit  <= 1'b0;
         slave_on          <= 1'b0;
         direction_bit     <= 1'b0;
         ack_detect_flag   <= 1'b0;
         start_detect_flag <= 1'b0;
         stop_detect_flag  <= 1'b0;
         addr_match_flag   <= 1'b0;
         ext_code_flag     <= 1'b0;
         bus_busy_flag     <= 1'b0;
         start_reject_flag <= 1'b0;
         start_request     <= 1'b0;
         stop_request      <= 1'b0;
      end else begin
         if (~en_d) begin
            bus_busy_flag <= ~start_without_stop_enable;
         end
         if (wr_ctl) begin
            start_request <= start_request | reg_wdata[CTL_START];
            stop_request  <= stop_request | reg_wdata[CTL_STOP];
            if (reg_wdata[CTL_START]) begin
               start_reject_flag <= 1'b0;
            end
         end
         if (scl_rise & in_byte) begin
            rx_bit <= sda_q;
         end
         if (scl_rise & ~in_byte) begin
            ack_detect_flag <= ~sda_q;
         end
         if (scl_fall) begin
            skip_fall <= 1'b0;
         end
         if (bit_fall) begin
            bit_cnt <= in_byte ? bit_cnt + 4'h1 : 4'h0;
            if (in_byte) begin
               shift_data_reg <= shift_next;
               out_latch      <= shift_data_reg[6];
            end
         end
         if (last_fall & addr_phase) begin
            addr_match_flag <= addr_hit;
            ext_code_flag   <= ext_hit;
            direction_bit   <= master_state_bit ? ~shift_next[0] : shift_next[0];
            if (to_slave) begin
               slave_on <= 1'b1;
            end
         end
         if (ack_fall) begin
            addr_phase <= 1'b0;
         end
         if (slave_nak) begin
            slave_on <= 1'b0;
            evt_xfer <= 1'b1;
         end
         if (wr_shift & (state != S_XFER)) begin
            shift_data_reg <= reg_wdata[7:0];
            out_latch      <= reg_wdata[7];
         end
         if (start_seen) begin
            start_detect_flag <= 1'b1;
            stop_detect_flag  <= 1'b0;
            bus_busy_flag     <= 1'b1;
            bit_cnt           <= 4'h0;
            skip_fall         <= 1'b1;
            addr_phase        <= 1'b1;
            slave_on          <= 1'b0;
         end
         if (stop_seen) begin
            stop_detect_flag  <= 1'b1;
            start_detect_flag <= 1'b0;
            bus_busy_flag     <= 1'b0;
            addr_phase        <= 1'b0;
            slave_on          <= 1'b0;
            evt_xfer          <= stop_irq_enable;
         end
         unique case (state)
            S_IDLE: begin
               drv <= '0;
               if (part_now & wait_hit) begin
                  state    <= S_WAIT;
                  evt_xfer <= 1'b1;
               end else if (to_slave) begin
                  state <= S_XFER;
               end else if (start_request & ~bus_busy_flag & ~stop_seen) begin
                  state <= S_START;
                  ph    <= 2'h0;
               end else if (start_request & bus_busy_flag & reservation_disable) begin
                  start_request     <= 1'b0;
                  start_reject_flag <= 1'b1;
                  evt_rej           <= 1'b1;
               end
            end
            S_XFER: begin
               drv.dat_low <= drive_low;
               if (master_state_bit & tick) begin
                  if (drv.clk_low) begin
                     drv.clk_low <= 1'b0;
                  end else if (scl_q) begin
                     drv.clk_low <= 1'b1;
                  end
               end else if (~master_state_bit) begin
                  drv.clk_low <= 1'b0;
               end
               if (stop_seen | slave_nak) begin
                  state            <= S_IDLE;
                  master_state_bit <= 1'b0;
               end else if (arb_lost) begin
                  master_state_bit <= 1'b0;
                  evt_arb          <= 1'b1;
                  state            <= S_IDLE;
               end else if (part_now & wait_hit) begin
                  state       <= S_WAIT;
                  drv.clk_low <= 1'b1;
                  evt_xfer    <= 1'b1;
               end else if (~part_now) begin
                  state <= S_IDLE;
               end
            end
            S_WAIT: begin
               drv.clk_low <= 1'b1;
               drv.dat_low <= drive_low;
               if (stop_seen) begin
                  state <= S_IDLE;
               end else if (master_state_bit & stop_request) begin
                  state <= S_STOP;
                  ph    <= 2'h0;
               end else if (master_state_bit & start_request) begin
                  state <= S_START;
                  ph    <= 2'h0;
               end else if (wait_free) begin
                  state       <= S_XFER;
                  drv.clk_low <= 1'b0;
               end
            end
            S_START: begin
               unique case (ph)
                  2'h0: begin
                     drv.dat_low <= 1'b0;
                     if (tick) begin
                        ph <= 2'h1;
                     end
                  end
                  2'h1: begin
                     drv.clk_low <= 1'b0;
                     if (tick & scl_q & sda_q) begin
                        ph <= 2'h2;
                     end
                  end
                  2'h2: begin
                     drv.dat_low <= 1'b1;
                     if (tick) begin
                        ph <= 2'h3;
                     end
                  end
                  2'h3: begin
                     drv.clk_low <= 1'b1;
                     if (tick) begin
                        master_state_bit <= 1'b1;
                        start_request    <= 1'b0;
                        state            <= S_WAIT;
                     end
                  end
               endcase
            end
            S_STOP: begin
               unique case (ph)
                  2'h0: begin
                     drv.dat_low <= 1'b1;
                     if (tick) begin
                        ph <= 2'h1;
                     end
                  end
                  2'h1: begin
                     drv.clk_low <= 1'b0;
                     if (tick & scl_q) begin
                        ph <= 2'h2;
                     end
                  end
                  default: begin
                     drv.dat_low      <= 1'b0;
                     master_state_bit <= 1'b0;
                     stop_request     <= 1'b0;
                     state            <= S_IDLE;
                  end
               endcase
            end
         endcase
      end
   end

endmodule

//--- rtl/i2c_mm_pkg.sv
package i2c_mm_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;

   // register offsets (byte addresses)
   localparam logic [4:0] OFF_SHIFT   = 5'h00;
   localparam logic [4:0] OFF_CONTROL = 5'h04;
   localparam logic [4:0] OFF_STATUS  = 5'h08;
   localparam logic [4:0] OFF_FLAG    = 5'h0C;
   localparam logic [4:0] OFF_CLKSEL  = 5'h10;
   localparam logic [4:0] OFF_OWNADR  = 5'h14;
   localparam logic [4:0] OFF_IRQSTAT = 5'h18;
   localparam logic [4:0] OFF_IRQMASK = 5'h1C;

   // control_reg fields
   localparam int CTL_START    = 0;
   localparam int CTL_STOP     = 1;
   localparam int CTL_ACK_EN   = 2;
   localparam int CTL_WAIT_SEL = 3;
   localparam int CTL_STOP_IE  = 4;
   localparam int CTL_WAIT_REL = 5;
   localparam int CTL_ENABLE   = 7;

   // bus_status_reg fields
   localparam int ST_ACK_DET   = 0;
   localparam int ST_START_DET = 1;
   localparam int ST_STOP_DET  = 2;
   localparam int ST_DIR       = 3;
   localparam int ST_ADR_MATCH = 4;
   localparam int ST_EXT_CODE  = 5;
   localparam int ST_MASTER    = 7;

   // bus_flag_reg fields
   localparam int FL_RSV_DIS   = 0;
   localparam int FL_NO_STOP   = 1;
   localparam int FL_BUSY      = 6;
   localparam int FL_START_REJ = 7;

   // clock_select_reg fields
   localparam int CS_DATA_LVL  = 0;
   localparam int CS_CLK_LVL   = 1;
   localparam int CS_DIV_LSB   = 8;

   // irq status / mask fields
   localparam int IRQ_XFER     = 0;
   localparam int IRQ_ARB      = 1;
   localparam int IRQ_REJECT   = 2;

   // reset values; divider plus one is half a bus clock period in ref_clk cycles
   localparam logic [7:0]  CTL_RST    = 8'h00;
   localparam logic [1:0]  FLAG_RST   = 2'h0;
   localparam logic [7:0]  DIV_RST    = 8'hFA;
   localparam logic [7:0]  OWNADR_RST = 8'h00;
   localparam logic [2:0]  IRQ_RST    = 3'h0;
   localparam logic [3:0]  BIT_ACK    = 4'h8;
   localparam logic [3:0]  BIT_LAST   = 4'h7;

   typedef struct packed {
      logic clk_low;
      logic dat_low;
   } line_drive_s;

   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_XFER  = 5'b00010,
      S_WAIT  = 5'b00100,
      S_START = 5'b01000,
      S_STOP  = 5'b10000
   } eng_state_e;

endpackage

//--- verif/i2c_mm_checker.sv
`timescale 1ns/1ps
module i2c_mm_checker
   import i2c_mm_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              srst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              bus_clock_pin_in,
   input wire logic              bus_clock_pin_out,
   input wire logic              bus_clock_pin_oe,
   input wire logic              bus_data_pin_in,
   input wire logic              bus_data_pin_out,
   input wire logic              bus_data_pin_oe,
   input wire logic              transfer_irq
);
   logic [2:0] mask_q;
   logic       ctl_en;
   logic       mst;
   wire        wr_ctl = reg_wr && reg_addr == OFF_CONTROL;
   wire        rel    = reg_wr && (reg_addr == OFF_SHIFT && reg_wdata[7:0] == 8'hFF
                                   || wr_ctl && reg_wdata[CTL_WAIT_REL]);

   // shadows of mask, enable and any master request
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mask_q <= 3'h0;
         ctl_en <= 1'b0;
         mst    <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == OFF_IRQMASK) mask_q <= reg_wdata[2:0];
         if (wr_ctl) ctl_en <= reg_wdata[CTL_ENABLE];
         if (wr_ctl && reg_wdata[CTL_START]) mst <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_open_drain_out: assert property (!bus_clock_pin_out && !bus_data_pin_out)
      else $error("pin output not low");
   a_read_window: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_irq_masked: assert property ((mask_q == 3'h0) [*2] |-> !transfer_irq)
      else $error("interrupt while masked");
   a_idle_released: assert property ((!ctl_en) [*3] |-> !bus_clock_pin_oe && !bus_data_pin_oe)
      else $error("lines driven while disabled");
   a_wait_release: assert property (!mst && bus_clock_pin_oe && rel |-> ##[1:2] !bus_clock_pin_oe)
      else $error("wait not released");
   a_wait_cause: assert property (!mst && $fell(bus_clock_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("wait ended without host write");
   a_stretch_low: assert property (!mst && $rose(bus_clock_pin_oe) |-> !bus_clock_pin_in)
      else $error("clock held outside low phase");
   a_data_in_low: assert property (!mst && $changed(bus_data_pin_oe) |-> !bus_clock_pin_in)
      else $error("data changed while clock high");

   c_irq: cover property ($rose(transfer_irq));
   c_wait: cover property ($fell(bus_clock_pin_oe));
   c_ack: cover property ($rose(bus_data_pin_oe));
endmodule

//--- verif/bus_master.sv
`timescale 1ns/1ps
module bus_master (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low,
   output logic      hang
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      hang    = 1'b0;
   end
   // clock stretching by the slave, bounded
   task automatic wait_high();
      int n;
      for (n = 0; n < 4000 && scl !== 1'b1; n++) #10;
      if (scl !== 1'b1) hang = 1'b1;
   endtask
   // keep pin changes off the system clock edges
   task automatic align();
      while (($time % 10) != 5) #1;
   endtask
   task automatic start();
      align();
      #40 sda_low = 1'b1;
      #40 scl_low = 1'b1;
   endtask
   // nine clocks, msb first; a 1 releases the line
   task automatic xfer(input logic [7:0] tx, input logic ack_bit,
                       output logic [7:0] rx, output logic ack_seen);
      int i;
      align();
      for (i = 0; i < 9; i++) begin
         #40 sda_low = (i < 8) ? !tx[7-i] : !ack_bit;
         #80 scl_low = 1'b0;
         wait_high();
         #20 if (i < 8) rx[7-i] = sda; else ack_seen = sda;
         #20 scl_low = 1'b1;
      end
      #40 sda_low = 1'b0;
   endtask
   task automatic stop();
      align();
      #40 sda_low = 1'b1;
      #80 scl_low = 1'b0;
      wait_high();
      #40 sda_low = 1'b0;
      #80;
   endtask
endmodule

//--- verif/i2c_multimaster_and_slave_control_tb.sv
`timescale 1ns/1ps
module i2c_multimaster_and_slave_control_tb
   import i2c_mm_pkg::*;
();
   logic              ref_clk   = 1'b0;
   logic              srst      = 1'b1;
   logic [ADDR_W-1:0] reg_addr  = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_wr    = 1'b0;
   logic              reg_rd    = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic              bus_clock_pin_out;
   logic              bus_clock_pin_oe;
   logic              bus_data_pin_out;
   logic              bus_data_pin_oe;
   logic              transfer_irq;
   logic              m_scl;
   logic              m_sda;
   logic              hang;
   // open-drain lines with pull-ups
   wire               bus_clock_pin_in = !(bus_clock_pin_oe || m_scl);
   wire               bus_data_pin_in  = !(bus_data_pin_oe || m_sda);
   logic [31:0]       exp_q[$];
   logic [31:0]       e;
   logic              rd_d = 1'b0;
   logic [7:0]        d;
   logic [7:0]        rx;
   logic              ack;
   int                k;
   int                mismatches  = 0;
   int                check_count = 0;

   always #10 ref_clk = ~ref_clk;

   i2c_mm_ctrl i_i2c_mm_ctrl (.*);
   bus_master i_bus_master (.scl(bus_clock_pin_in), .sda(bus_data_pin_in), .scl_low(m_scl),
                            .sda_low(m_sda), .hang(hang));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: %h not %h", $time, msg, seen, exp);
      end
   endtask
   task automatic finish_test();
      check({15'h0, hang}, 16'h0, "bus clock stuck");
      repeat (3) @(posedge ref_clk);
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   // expected value and mask noted for the read monitor
   task automatic rd(input logic [4:0] a, input logic [15:0] v, input logic [15:0] m);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_q.push_back({m, v});
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
   endtask
   task automatic wait_irq(input logic lvl);
      int n;
      for (n = 0; n < 20000 && transfer_irq !== lvl; n++) @(posedge ref_clk);
      check({15'h0, transfer_irq}, {15'h0, lvl}, "interrupt level");
      if (transfer_irq !== lvl) finish_test();
   endtask

   always @(posedge ref_clk) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         check(reg_rdata & e[31:16], e[15:0], "read data");
      end
      rd_d <= reg_rd;
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(51));
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      rd(OFF_CLKSEL, 16'hFA00, 16'hFF00);
      rd(OFF_CONTROL, 16'h0000, 16'hFFFF);
      rd(OFF_IRQSTAT, 16'h0000, 16'hFFFF);
      rd(5'h02, 16'h0000, 16'hFFFF);
      wr(OFF_CLKSEL, 16'h0300);
      wr(OFF_OWNADR, 16'h00A4);
      wr(OFF_IRQMASK, 16'h0001);
      wr(OFF_CONTROL, 16'h009C);
      rd(OFF_FLAG, 16'h0040, 16'h00C3);
      rd(OFF_CLKSEL, 16'h0303, 16'hFF03);
      $display("test reset and setup done");
      i_bus_master.start();
      i_bus_master.xfer(8'hA4, 1'b1, rx, ack);
      check({15'h0, ack}, 16'h0000, "address acknowledge");
      wait_irq(1'b1);
      rd(OFF_STATUS, 16'h0010, 16'h0098);
      wr(OFF_IRQMASK, 16'h0000);
      wait_irq(1'b0);
      wr(OFF_IRQMASK, 16'h0001);
      wait_irq(1'b1);
      wr(OFF_IRQSTAT, 16'h0001);
      wait_irq(1'b0);
      for (k = 0; k < 3; k++) begin
         if (k == 1) wr(OFF_SHIFT, 16'h00FF);
         else wr(OFF_CONTROL, (k == 0) ? 16'h00BC : 16'h00B8);
         d = 8'($urandom());
         i_bus_master.xfer(d, 1'b1, rx, ack);
         check({15'h0, ack}, {15'h0, k == 2}, "receiver acknowledge");
         if (k < 2) wait_irq(1'b1);
         repeat (8) @(posedge ref_clk);
         rd(OFF_SHIFT, {8'h00, d}, 16'h00FF);
         wr(OFF_IRQSTAT, 16'h0001);
      end
      wr(OFF_CONTROL, 16'h00BC);
      i_bus_master.stop();
      wait_irq(1'b1);
      rd(OFF_STATUS, 16'h0004, 16'h0004);
      wr(OFF_IRQSTAT, 16'h0001);
      $display("test slave receive done");
      i_bus_master.start();
      i_bus_master.xfer(8'hA5, 1'b1, rx, ack);
      check({15'h0, ack}, 16'h0000, "address acknowledge");
      wait_irq(1'b1);
      rd(OFF_STATUS, 16'h0018, 16'h0098);
      wr(OFF_IRQSTAT, 16'h0001);
      for (k = 0; k < 2; k++) begin
         d = 8'($urandom());
         wr(OFF_SHIFT, {8'h00, d});
         i_bus_master.xfer(8'hFF, k == 1, rx, ack);
         check({8'h00, rx}, {8'h00, d}, "transmitted byte");
         wait_irq(1'b1);
         wr(OFF_IRQSTAT, 16'h0001);
      end
      check({15'h0, bus_clock_pin_oe}, 16'h0000, "clock held after last byte");
      i_bus_master.stop();
      wait_irq(1'b1);
      wr(OFF_IRQSTAT, 16'h0001);
      $display("test slave transmit done");
      wr(OFF_CONTROL, 16'h008C);
      i_bus_master.start();
      i_bus_master.xfer(8'h10, 1'b1, rx, ack);
      check({15'h0, ack}, 16'h0001, "foreign address acknowledged");
      // start request while the bus is busy and reservation is off
      wr(OFF_FLAG, 16'h0001);
      wr(OFF_CONTROL, 16'h008D);
      rd(OFF_FLAG, 16'h00C1, 16'h00C3);
      rd(OFF_IRQSTAT, 16'h0004, 16'h0004);
      i_bus_master.stop();
      repeat (20) @(posedge ref_clk);
      rd(OFF_IRQSTAT, 16'h0000, 16'h0001);
      check({15'h0, transfer_irq}, 16'h0000, "stop interrupt while disabled");
      $display("test address mismatch done");
      finish_test();
   end
endmodule

bind i2c_mm_ctrl i2c_mm_checker i_i2c_mm_checker (.*);
